// >>> rrcp_pkg.sv
// package of constants and types for the remote register command port
package rrcp_pkg;
  localparam int WORD_W = 16;
  localparam logic [15:0] MON_CODE_MAX = 16'h001A;
  localparam logic [15:0] ANSWER_OK = 16'h0000;
  localparam logic [15:0] ERR_MON_CODE = 16'h0001;
  localparam logic [15:0] ERR_INSTR_CODE = 16'h0002;
  localparam logic [15:0] ERR_WRITE_DATA = 16'h0003;
  localparam logic [15:0] ERR_POS_DATA = 16'h0004;
  localparam logic [15:0] ERR_SPEED_DATA = 16'h0005;
  localparam logic [15:0] ERR_STATION = 16'h0006;
  localparam logic [15:0] INSTR_READ_LO = 16'h0100;
  localparam logic [15:0] INSTR_READ_HI = 16'h04FF;
  localparam logic [15:0] INSTR_WRITE_LO = 16'h8100;
  localparam logic [15:0] INSTR_WRITE_HI = 16'h84FF;
  localparam int TABLE_DEPTH = 64;
  localparam int TABLE_AW = 6;
  localparam int POS_MAX = 999999;
  localparam logic [15:0] BLOCK_MAX = 16'h00FF;
  localparam logic [15:0] SPEED_MAX_RST = 16'h0BB8;
  localparam int PAR_POS_SEL_BIT = 0;
  localparam int PAR_POS_UNSIGNED_BIT = 1;
  typedef enum logic [1:0] {
    RRCP_K_MON, RRCP_K_INSTR, RRCP_K_POS, RRCP_K_SPD
  } rrcp_kind_t;
endpackage : rrcp_pkg

// >>> rrcp_mon_if.sv
// interface carrying monitor lookups between top and monitor unit
interface rrcp_mon_if;
  logic [15:0] code_one;
  logic [15:0] code_two;
  logic [15:0] res_zero;
  logic [15:0] res_one;
  logic [15:0] res_two_lo;
  logic [15:0] res_two_hi;
  logic code_bad;
  modport top (output code_one, output code_two, input res_zero,
    input res_one, input res_two_lo, input res_two_hi, input code_bad);
  modport unit (input code_one, input code_two, output res_zero,
    output res_one, output res_two_lo, output res_two_hi,
    output code_bad);
endinterface : rrcp_mon_if

// >>> rrcp_monitor.sv
// monitor item selection from the status bus
module rrcp_monitor (
  rrcp_mon_if.unit mon,
  input wire logic two_station,
  input wire logic [27*16-1:0] status_flat
);
  // ***************************************************************
  // item lookup
  // ***************************************************************
  function automatic logic [15:0] item(
    input logic [15:0] code, input logic [27*16-1:0] flat);
    item = 16'h0000;
    if (code <= rrcp_pkg::MON_CODE_MAX) begin
      item = flat[code[4:0]*16 +: 16];
    end
  endfunction : item

  function automatic logic bad(input logic [15:0] code);
    bad = code > rrcp_pkg::MON_CODE_MAX;
  endfunction : bad

  // item at code+1 is the upper half, else sign extend
  function automatic logic [15:0] upper(
    input logic [15:0] code, input logic [27*16-1:0] flat);
    logic [15:0] lo;
    lo = item(code, flat);
    upper = {16{lo[15]}};
    if (code < rrcp_pkg::MON_CODE_MAX) begin
      upper = flat[(code[4:0] + 5'h01)*16 +: 16];
    end
  endfunction : upper

  always_comb begin
    mon.code_bad = bad(mon.code_one) | bad(mon.code_two);
    mon.res_zero = item(mon.code_one, status_flat); // RL1
    mon.res_one = two_station ? upper(mon.code_one, status_flat) // RL2 RL14
      : item(mon.code_two, status_flat); // RL3
    mon.res_two_lo = item(mon.code_two, status_flat); // RL4
    mon.res_two_hi = upper(mon.code_two, status_flat); // RL4 RL14
  end
endmodule : rrcp_monitor

// >>> rrcp_top.sv
// remote register command port of the servo amplifier
// Overview of operation
// RL1: monitor request loads item named by code one into result zero
// RL2: two stations: 32-bit item one gives low in zero, high in one
// RL3: one station: item named by code two lands in result one
// RL4: two stations: 32-bit item two gives low in five, high in six
// RL5: instruction request executes code then raises completion flag
// RL6: write instructions store write data, then raise completion flag
// RL7: two stations: position request latches block number from low word
// RL8: direct mode: 32-bit position within +-999999 or 0..999999
// RL9: parameter 41 picks block number or direct position data
// RL10: two stations: speed request accepts speed up to permissible speed
// RL11: unsupported code or bad data puts nonzero error in answer word
// RL12: all requests normal gives 0000 in answer word
// RL13: read instruction places fetched value in read data word
// RL14: upper result word sign-extends when no upper half exists
// RL15: one station uses only words zero to three
// RL16: controller holds request until flag, device clears after release
// RL17: result words hold until a new request of the same kind completes
module rrcp_top #(
  parameter int DEPTH = rrcp_pkg::TABLE_DEPTH
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic two_station,
  input wire logic [15:0] par_41,
  input wire logic [15:0] speed_limit,
  input wire logic [27*16-1:0] status_flat,
  input wire logic [15:0] monitor_code_one,
  input wire logic [15:0] monitor_code_two,
  input wire logic [15:0] instruction_word,
  input wire logic [15:0] write_data_word,
  input wire logic [15:0] position_word_low,
  input wire logic [15:0] position_word_high,
  input wire logic [15:0] speed_command_word,
  input wire logic monitor_request_bit,
  input wire logic instruction_request_bit,
  input wire logic position_request_bit,
  input wire logic speed_request_bit,
  output logic monitor_done_flag,
  output logic instruction_completion_flag,
  output logic position_done_flag,
  output logic speed_done_flag,
  output logic [15:0] monitor_result_zero,
  output logic [15:0] monitor_result_one,
  output logic [15:0] answer_word,
  output logic [15:0] read_data_word,
  output logic [15:0] monitor_two_result_low,
  output logic [15:0] monitor_two_result_high,
  output logic [15:0] block_number,
  output logic [31:0] position_command,
  output logic position_is_block,
  output logic [15:0] speed_command
);
  // ***************************************************************
  // input synchronisers
  // ***************************************************************
  logic [3:0] req_s1_q;
  logic [3:0] req_s2_q;
  logic [3:0] req;
  logic ts_s1_q;
  logic ts_s2_q;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      req_s1_q <= 4'h0;
      req_s2_q <= 4'h0;
      ts_s1_q <= 1'b0;
      ts_s2_q <= 1'b0;
    end else begin
      req_s1_q <= {speed_request_bit, position_request_bit,
        instruction_request_bit, monitor_request_bit};
      req_s2_q <= req_s1_q;
      ts_s1_q <= two_station;
      ts_s2_q <= ts_s1_q;
    end
  end
  // words are qualified by the synchronised request, stable by then
  assign req = req_s2_q;

  // ***************************************************************
  // monitor unit
  // ***************************************************************
  rrcp_mon_if mon_if ();
  assign mon_if.code_one = monitor_code_one;
  assign mon_if.code_two = monitor_code_two;

  rrcp_monitor u_mon (
    .mon(mon_if.unit),
    .two_station(ts_s2_q),
    .status_flat(status_flat)
  );

  // ***************************************************************
  // request edge detection and completion flags
  // ***************************************************************
  logic [3:0] done_q;
  logic [3:0] start;
  assign start = req & ~done_q;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      done_q <= 4'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (start[i]) begin
          done_q[i] <= 1'b1; // RL5 RL6
        end else if (!req[i]) begin
          done_q[i] <= 1'b0; // RL16
        end
      end
    end
  end
  assign monitor_done_flag = done_q[rrcp_pkg::RRCP_K_MON];
  assign instruction_completion_flag = done_q[rrcp_pkg::RRCP_K_INSTR];
  assign position_done_flag = done_q[rrcp_pkg::RRCP_K_POS];
  assign speed_done_flag = done_q[rrcp_pkg::RRCP_K_SPD];

  // ***************************************************************
  // checks
  // ***************************************************************
  function automatic logic in_range(input logic [15:0] v,
    input logic [15:0] lo, input logic [15:0] hi);
    in_range = (v >= lo) && (v <= hi);
  endfunction : in_range

  logic instr_rd;
  logic instr_wr;
  logic [31:0] pos_val;
  logic pos_neg;
  logic [31:0] pos_mag;
  logic pos_bad;
  logic spd_bad;
  logic blk_mode;

  assign instr_rd = in_range(instruction_word, rrcp_pkg::INSTR_READ_LO,
    rrcp_pkg::INSTR_READ_HI);
  assign instr_wr = in_range(instruction_word, rrcp_pkg::INSTR_WRITE_LO,
    rrcp_pkg::INSTR_WRITE_HI);
  assign blk_mode = par_41[rrcp_pkg::PAR_POS_SEL_BIT]; // RL9
  assign pos_val = {position_word_high, position_word_low}; // RL8
  assign pos_neg = pos_val[31];
  assign pos_mag = pos_neg ? (32'h0 - pos_val) : pos_val;

  always_comb begin
    pos_bad = 1'b0;
    if (blk_mode) begin
      pos_bad = position_word_low > rrcp_pkg::BLOCK_MAX;
    end else if (pos_mag > 32'(rrcp_pkg::POS_MAX)) begin
      pos_bad = 1'b1; // RL8
    end else if (pos_neg && par_41[rrcp_pkg::PAR_POS_UNSIGNED_BIT]) begin
      pos_bad = 1'b1; // RL8
    end
    spd_bad = speed_command_word > speed_limit; // RL10
  end

  // ***************************************************************
  // parameter and point table store
  // ***************************************************************
  logic [15:0] table_q [DEPTH];
  logic [rrcp_pkg::TABLE_AW-1:0] tidx;
  assign tidx = instruction_word[rrcp_pkg::TABLE_AW-1:0];

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        table_q[i] <= 16'h0000;
      end
    end else if (start[rrcp_pkg::RRCP_K_INSTR] && instr_wr) begin
      table_q[tidx] <= write_data_word; // RL6
    end
  end

  // ***************************************************************
  // monitor results
  // ***************************************************************
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      monitor_result_zero <= 16'h0000;
      monitor_result_one <= 16'h0000;
      monitor_two_result_low <= 16'h0000;
      monitor_two_result_high <= 16'h0000;
    end else if (start[rrcp_pkg::RRCP_K_MON]) begin // RL17
      monitor_result_zero <= mon_if.res_zero; // RL1
      monitor_result_one <= mon_if.res_one; // RL2 RL3
      if (ts_s2_q) begin
        monitor_two_result_low <= mon_if.res_two_lo; // RL4
        monitor_two_result_high <= mon_if.res_two_hi; // RL4
      end else begin
        monitor_two_result_low <= 16'h0000; // RL15
        monitor_two_result_high <= 16'h0000; // RL15
      end
      if (mon_if.code_bad) begin
        monitor_result_zero <= 16'h0000; // RL11
        monitor_result_one <= 16'h0000;
        monitor_two_result_low <= 16'h0000;
        monitor_two_result_high <= 16'h0000;
      end
    end
  end

  // ***************************************************************
  // read data
  // ***************************************************************
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      read_data_word <= 16'h0000;
    end else if (start[rrcp_pkg::RRCP_K_INSTR] && instr_rd) begin
      read_data_word <= table_q[tidx]; // RL13 RL17
    end
  end

  // ***************************************************************
  // position and speed commands
  // ***************************************************************
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      block_number <= 16'h0000;
      position_command <= 32'h0000_0000;
      position_is_block <= 1'b0;
    end else if (start[rrcp_pkg::RRCP_K_POS] && ts_s2_q && !pos_bad) begin
      position_is_block <= blk_mode; // RL9
      if (blk_mode) begin
        block_number <= position_word_low; // RL7
      end else begin
        position_command <= pos_val; // RL8
      end
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      speed_command <= 16'h0000;
    end else if (start[rrcp_pkg::RRCP_K_SPD] && ts_s2_q && !spd_bad) begin
      speed_command <= speed_command_word; // RL10
    end
  end

  // ***************************************************************
  // answer word
  // ***************************************************************
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      answer_word <= rrcp_pkg::ANSWER_OK;
    end else if (start[rrcp_pkg::RRCP_K_MON] && mon_if.code_bad) begin
      answer_word <= rrcp_pkg::ERR_MON_CODE; // RL11
    end else if (start[rrcp_pkg::RRCP_K_INSTR] && !instr_rd && !instr_wr) begin
      answer_word <= rrcp_pkg::ERR_INSTR_CODE; // RL11
    end else if ((start[rrcp_pkg::RRCP_K_POS] || start[rrcp_pkg::RRCP_K_SPD])
        && !ts_s2_q) begin
      answer_word <= rrcp_pkg::ERR_STATION; // RL15
    end else if (start[rrcp_pkg::RRCP_K_POS] && pos_bad) begin
      answer_word <= rrcp_pkg::ERR_POS_DATA; // RL11
    end else if (start[rrcp_pkg::RRCP_K_SPD] && spd_bad) begin
      answer_word <= rrcp_pkg::ERR_SPEED_DATA; // RL11
    end else if (|start) begin
      answer_word <= rrcp_pkg::ANSWER_OK; // RL12
    end
  end
endmodule : rrcp_top

// >>> rrcp_plc_model.sv
// controller model driving the request bits of the port
module rrcp_plc_model (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic [3:0] go,
  input wire logic [3:0] done,
  output logic [3:0] req,
  output logic busy
);
  logic [3:0] wl_q;
  assign busy = |{req, wl_q};
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      req <= 4'h0;
      wl_q <= 4'h0;
    end else begin
      for (int k = 0; k < 4; k++) begin
        if (go[k] && !req[k] && !wl_q[k]) begin
          req[k] <= 1'b1;
        end else if (req[k] && done[k]) begin
          req[k] <= 1'b0;
          wl_q[k] <= 1'b1;
        end else if (wl_q[k] && !done[k]) begin
          wl_q[k] <= 1'b0;
        end
      end
    end
  end
endmodule : rrcp_plc_model

// >>> rrcp_top_chk.sv
// assertion checker of the remote register command port
module rrcp_top_chk #(
  parameter int DEPTH = rrcp_pkg::TABLE_DEPTH
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic monitor_request_bit,
  input wire logic instruction_request_bit,
  input wire logic monitor_done_flag,
  input wire logic instruction_completion_flag,
  input wire logic position_done_flag,
  input wire logic speed_done_flag,
  input wire logic [15:0] monitor_result_zero,
  input wire logic [15:0] answer_word,
  input wire logic [15:0] read_data_word,
  input wire logic [15:0] block_number
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);
  sequence s_mon_go;
    $rose(monitor_request_bit) && !monitor_done_flag;
  endsequence
  sequence s_ins_go;
    $rose(instruction_request_bit) && !instruction_completion_flag;
  endsequence
  a_mon_answer: assert property (
    s_mon_go |-> ##[2:3] monitor_done_flag)
    else $error("monitor flag late");
  a_ins_answer: assert property (
    s_ins_go |-> ##[2:3] instruction_completion_flag)
    else $error("instruction flag late");
  a_mon_stands: assert property (
    monitor_done_flag && monitor_request_bit |=> monitor_done_flag)
    else $error("monitor flag dropped early");
  a_ins_clears: assert property (
    $fell(instruction_request_bit) |-> ##[1:4] !instruction_completion_flag)
    else $error("instruction flag not cleared");
  a_result_hold: assert property (
    !$rose(monitor_done_flag) |-> $stable(monitor_result_zero))
    else $error("monitor result changed");
  a_read_hold: assert property (
    !$rose(instruction_completion_flag) |-> $stable(read_data_word))
    else $error("read data changed");
  a_block_hold: assert property (
    !$rose(position_done_flag) |-> $stable(block_number))
    else $error("block number changed");
  a_answer_hold: assert property (
    !($rose(monitor_done_flag) || $rose(instruction_completion_flag)
    || $rose(position_done_flag) || $rose(speed_done_flag))
    |-> $stable(answer_word))
    else $error("answer changed");
  a_bad_zero: assert property (
    $rose(monitor_done_flag) && answer_word == rrcp_pkg::ERR_MON_CODE
    |-> monitor_result_zero == 16'h0000)
    else $error("bad code result not zero");
endmodule : rrcp_top_chk
bind rrcp_top rrcp_top_chk #(.DEPTH(DEPTH)) u_chk (
  .clk_sys(clk_sys),
  .arst_n(arst_n),
  .monitor_request_bit(monitor_request_bit),
  .instruction_request_bit(instruction_request_bit),
  .monitor_done_flag(monitor_done_flag),
  .instruction_completion_flag(instruction_completion_flag),
  .position_done_flag(position_done_flag),
  .speed_done_flag(speed_done_flag),
  .monitor_result_zero(monitor_result_zero),
  .answer_word(answer_word),
  .read_data_word(read_data_word),
  .block_number(block_number)
);

// >>> tb_rrcp_top.sv
// self-checking bench of the remote register command port
module tb_rrcp_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys, arst_n, two_station, busy;
  logic [15:0] par_41, speed_limit, monitor_code_one, monitor_code_two;
  logic [15:0] instruction_word, write_data_word, position_word_low;
  logic [15:0] position_word_high, speed_command_word;
  logic [27*16-1:0] status_flat;
  wire logic monitor_request_bit, instruction_request_bit;
  wire logic position_request_bit, speed_request_bit;
  logic monitor_done_flag, instruction_completion_flag;
  logic position_done_flag, speed_done_flag, position_is_block;
  logic [15:0] monitor_result_zero, monitor_result_one, answer_word;
  logic [15:0] read_data_word, monitor_two_result_low;
  logic [15:0] monitor_two_result_high, block_number, speed_command;
  logic [31:0] position_command;
  logic [3:0] go;
  int n_fail, checks;
  rrcp_top dut (.*);
  rrcp_plc_model u_plc (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .go(go),
    .done({speed_done_flag, position_done_flag,
      instruction_completion_flag, monitor_done_flag}),
    .req({speed_request_bit, position_request_bit,
      instruction_request_bit, monitor_request_bit}),
    .busy(busy)
  );
  function automatic logic [15:0] stat(input int k);
    return 16'h8000 | 16'(k);
  endfunction : stat
  task automatic end_sim();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_sim
  task automatic chk(input string nm, input logic [15:0] e,
    input logic [15:0] g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic mode(input logic ts, input logic [15:0] p);
    two_station = ts;
    par_41 = p;
    repeat (4) @(posedge clk_sys);
    #1;
  endtask : mode
  task automatic run(input logic [3:0] m);
    int n;
    n = 0;
    @(posedge clk_sys);
    #1 go = m;
    @(posedge clk_sys);
    #1 go = 4'h0;
    while (busy && n < 40) begin
      @(posedge clk_sys);
      #1 n++;
    end
    if (n >= 40) begin
      n_fail++;
      end_sim();
    end
  endtask : run
  task automatic t_mon();
    {monitor_code_one, monitor_code_two} = {16'h0003, 16'h0005};
    run(4'h1);
    chk("res0", stat(3), monitor_result_zero);
    chk("res1", stat(5), monitor_result_one);
    chk("lo2", 16'h0000, monitor_two_result_low);
    chk("ans", rrcp_pkg::ANSWER_OK, answer_word);
    mode(1'b1, 16'h0000);
    {monitor_code_one, monitor_code_two} = {16'h000A, 16'h001A};
    run(4'h1);
    chk("res0", stat(10), monitor_result_zero);
    chk("res1", stat(11), monitor_result_one);
    chk("lo2", stat(26), monitor_two_result_low);
    chk("hi2", 16'hFFFF, monitor_two_result_high);
    monitor_code_one = 16'h001B;
    run(4'h1);
    chk("ans", rrcp_pkg::ERR_MON_CODE, answer_word);
    chk("res1", 16'h0000, monitor_result_one);
    monitor_code_one = 16'h0000;
  endtask : t_mon
  task automatic t_ins();
    {instruction_word, write_data_word} = {16'h8105, 16'h1234};
    run(4'h2);
    chk("ans", rrcp_pkg::ANSWER_OK, answer_word);
    instruction_word = 16'h0105;
    run(4'h2);
    chk("rd", 16'h1234, read_data_word);
    instruction_word = 16'h0000;
    run(4'h2);
    chk("ans", rrcp_pkg::ERR_INSTR_CODE, answer_word);
    chk("rd", 16'h1234, read_data_word);
  endtask : t_ins
  task automatic t_pos();
    mode(1'b1, 16'h0001);
    position_word_low = 16'h0012;
    run(4'h4);
    chk("blk", 16'h0012, block_number);
    chk("isb", 16'h0001, 16'(position_is_block));
    mode(1'b1, 16'h0000);
    {position_word_high, position_word_low} = 32'hFFF0BDC1;
    run(4'h4);
    chk("pcl", 16'hBDC1, position_command[15:0]);
    chk("pch", 16'hFFF0, position_command[31:16]);
    {position_word_high, position_word_low} = 32'h000F4240;
    run(4'h4);
    chk("ans", rrcp_pkg::ERR_POS_DATA, answer_word);
    chk("pch", 16'hFFF0, position_command[31:16]);
  endtask : t_pos
  task automatic t_spd();
    speed_command_word = 16'h0BB8;
    run(4'h8);
    chk("spd", 16'h0BB8, speed_command);
    speed_command_word = 16'h0BB9;
    run(4'h8);
    chk("ans", rrcp_pkg::ERR_SPEED_DATA, answer_word);
    mode(1'b0, 16'h0000);
    speed_command_word = 16'h0100;
    run(4'hC);
    chk("ans", rrcp_pkg::ERR_STATION, answer_word);
    chk("spd", 16'h0BB8, speed_command);
  endtask : t_spd
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial begin
    {arst_n, two_station, go, par_41, speed_command_word} = '0;
    {monitor_code_one, monitor_code_two, instruction_word} = '0;
    {write_data_word, position_word_low, position_word_high} = '0;
    speed_limit = 16'h0BB8;
    n_fail = 0;
    checks = 0;
    for (int k = 0; k < 27; k++) begin
      status_flat[16*k +: 16] = stat(k);
    end
    repeat (20) @(posedge clk_sys);
    #1 arst_n = 1'b1;
    t_mon();
    t_ins();
    t_pos();
    t_spd();
    end_sim();
  end
endmodule : tb_rrcp_top
